// >>> shared/bcs_pkg.sv
// Constants for the bridge command and primary status register pair
package bcs_pkg;

   // ---------------------------------------------------------------
   // Configuration space location
   // ---------------------------------------------------------------
   localparam int BCS_ADDR_W = 8;
   localparam logic [7:0] BCS_OFS_CMD_STS = 8'h04;
   localparam logic [31:0] BCS_RD_ZERO = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Command half, bits 15:0 of the word
   // ---------------------------------------------------------------
   localparam int BCS_CMD_W = 16;
   localparam int BCS_CMD_IO = 0;
   localparam int BCS_CMD_MEM = 1;
   localparam int BCS_CMD_BME = 2;
   localparam int BCS_CMD_PER = 6;
   localparam int BCS_CMD_SERR = 8;
   localparam int BCS_CMD_INTD = 10;
   localparam logic [15:0] BCS_CMD_WR_MASK = 16'h0547;
   localparam logic [15:0] BCS_CMD_RST = 16'h0000;

   // ---------------------------------------------------------------
   // Primary status half, bit positions within the 32-bit word
   // ---------------------------------------------------------------
   localparam int BCS_STS_CAP = 20;
   localparam int BCS_STS_66M = 21;
   localparam int BCS_STS_FBB = 23;
   localparam int BCS_STS_DEVSEL_LO = 25;
   localparam int BCS_STS_DEVSEL_HI = 26;
   localparam logic BCS_STS_CAP_VAL = 1'b1;
   localparam logic BCS_STS_66M_VAL = 1'b0;
   localparam logic BCS_STS_FBB_VAL = 1'b0;
   localparam logic [1:0] BCS_STS_DEVSEL_VAL = 2'h0;

   // Write-one-to-clear flags, all in byte lane 3
   localparam int BCS_NUM_FLAGS = 6;
   localparam int BCS_FLAG_LANE = 3;
   localparam int BCS_F_MDPE = 0;
   localparam int BCS_F_STA = 1;
   localparam int BCS_F_RTA = 2;
   localparam int BCS_F_RMA = 3;
   localparam int BCS_F_SSE = 4;
   localparam int BCS_F_DPE = 5;
   localparam int BCS_FLAG_BIT [BCS_NUM_FLAGS] = '{24, 27, 28, 29, 30, 31};
   localparam logic [5:0] BCS_FLAG_RST = 6'h00;

endpackage

// >>> sim/bcs_cfg_host.sv
// Root complex model that issues configuration reads and writes
`timescale 1ns/1ps
module bcs_cfg_host
   import bcs_pkg::*;
(
   // Clock
   input wire logic clk,
   // Access strobes and payload
   output logic cfg_wr,
   output logic cfg_rd,
   output logic [BCS_ADDR_W-1:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   // Read answer
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rd_valid
);
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      cfg_be = 4'h0;
      cfg_wdata = 32'h0000_0000;
   end

   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   // Released payload is inverted so stale values never pose as live ones;
   // an idle cycle follows so a strobe is never lowered and raised at once
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      cfg_wr = 1'b1;
      @(posedge clk);
      #1;
      cfg_wr = 1'b0;
      cfg_wdata = ~d;
      cfg_addr = ~a;
      cfg_be = ~be;
      @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
      cfg_addr = a;
      cfg_rd = 1'b1;
      @(posedge clk);
      #1;
      cfg_rd = 1'b0;
      cfg_addr = ~a;
      d = cfg_rdata;
      v = cfg_rd_valid;
      @(posedge clk);
      #1;
   endtask
endmodule

// >>> sim/bcs_regs_tb.sv
// Self-checking testbench for the command and primary status registers
`timescale 1ns/1ps
module bcs_regs_tb;
   import bcs_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cfg_wr, cfg_rd, cfg_rd_valid;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata;
   logic [5:0] en, ev = 6'h00;
   logic [2:0] req = 3'h0, acc;
   logic fwd_mode = 1'b0, err_req = 1'b0, err_send, inta_req = 1'b0, inta_assert;
   logic [15:0] c, cw;
   int fails = 0;
   int cmp_count = 0;
   // Expected flag byte per event, parity response off then on
   logic [7:0] exp_f [2][6] = '{'{8'h80, 8'h00, 8'h80, 8'h08, 8'h10, 8'h20},
                                '{8'h81, 8'h01, 8'h80, 8'h08, 8'h10, 8'h20}};

   always #20 ref_clk = ~ref_clk;

   bcs_cfg_host bcs_cfg_host_inst (.clk(ref_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rd_valid(cfg_rd_valid));

   bcs_regs bcs_regs_inst (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CFG_WR(cfg_wr),
      .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata),
      .CFG_RDATA(cfg_rdata), .CFG_RD_VALID(cfg_rd_valid), .IO_SPACE_EN(en[0]),
      .MEM_SPACE_EN(en[1]), .BUS_MASTER_EN(en[2]), .PARITY_RESP_EN(en[3]),
      .SERR_EN(en[4]), .INT_DISABLE(en[5]), .PRI_IO_REQ(req[0]), .PRI_IO_ACCEPT(acc[0]),
      .PRI_MEM_RD_REQ(req[1]), .PRI_MEM_RD_ACCEPT(acc[1]), .SEC_FWD_REQ(req[2]),
      .SEC_FWD_ACCEPT(acc[2]), .FWD_MODE(fwd_mode), .ERR_MSG_REQ(err_req),
      .ERR_MSG_SEND(err_send), .INTA_REQ(inta_req), .INTA_ASSERT(inta_assert),
      .EV_POISON_CPL_RX(ev[0]), .EV_POISON_WR_TX(ev[1]), .EV_POISON_DET(ev[2]),
      .EV_CA_SENT(ev[3]), .EV_CA_RX(ev[4]), .EV_UR_RX(ev[5]));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      logic vv;
      bcs_cfg_host_inst.rd(a, x, vv);
      chk({31'h0, vv}, 32'h1);
      chk(x, exp);
   endtask

   task automatic pulse(input int i);
      ev[i] = 1'b1;
      @(posedge ref_clk);
      #1;
      ev = 6'h00;
   endtask

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      chk({26'h0, en}, 32'h0);
      rdchk(BCS_OFS_CMD_STS, 32'h0010_0000);
      $display("test reset done");
      req = 3'h7;
      inta_req = 1'b1;
      for (int i = 0; i < 16; i++) begin
         c = 16'h0001 << i;
         bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h3, {16'h0, c});
         rdchk(BCS_OFS_CMD_STS, {16'h0010, c & 16'h0547});
         chk({26'h0, en}, {26'h0, c[10], c[8], c[6], c[2:0]});
         chk({29'h0, acc}, {29'h0, c[2:0]});
         chk({31'h0, inta_assert}, {31'h0, ~c[10]});
      end
      bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h1, 32'h0000_ffff);
      bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h4, 32'hffff_ffff);
      rdchk(BCS_OFS_CMD_STS, 32'h0010_0047);
      // Unmapped dword reads zero and must not alias onto the command word
      bcs_cfg_host_inst.wr(8'h08, 4'hf, 32'hffff_ffff);
      rdchk(8'h08, 32'h0);
      rdchk(BCS_OFS_CMD_STS, 32'h0010_0047);
      $display("test command done");
      for (int p = 0; p < 2; p++) begin
         cw = (p == 1) ? 16'h0040 : 16'h0000;
         bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h3, {16'h0, cw});
         for (int i = 0; i < 6; i++) begin
            pulse(i);
            bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h8, 32'h0);
            rdchk(BCS_OFS_CMD_STS, {exp_f[p][i], 8'h10, cw});
            bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h8, 32'hff00_0000);
            rdchk(BCS_OFS_CMD_STS, {8'h00, 8'h10, cw});
         end
      end
      // Event landing on the same edge as the clearing write
      fork
         pulse(3);
         bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h8, 32'hff00_0000);
      join
      rdchk(BCS_OFS_CMD_STS, {8'h08, 8'h10, cw});
      // Ones in the flag lane must not clear anything while its byte enable is off
      bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h4, 32'hff00_0000);
      rdchk(BCS_OFS_CMD_STS, {8'h08, 8'h10, cw});
      bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h8, 32'hff00_0000);
      fork
         pulse(2);
         bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h8, 32'hff00_0000);
      join
      rdchk(BCS_OFS_CMD_STS, {8'h80, 8'h10, cw});
      bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h8, 32'hff00_0000);
      $display("test flags done");
      for (int k = 0; k < 4; k++) begin
         c = k[1] ? 16'h0100 : 16'h0000;
         bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h3, {16'h0, c});
         fwd_mode = k[0];
         err_req = 1'b1;
         #1;
         chk({31'h0, err_send}, {31'h0, k[0] & k[1]});
         @(posedge ref_clk);
         #1;
         err_req = 1'b0;
         rdchk(BCS_OFS_CMD_STS, {(k == 3) ? 8'h40 : 8'h00, 8'h10, c});
         bcs_cfg_host_inst.wr(BCS_OFS_CMD_STS, 4'h8, 32'hff00_0000);
      end
      $display("test error messages done");
      // Reset in mid-run must drop both the command bits and a pending flag
      pulse(5);
      sys_rst = 1'b1;
      @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      chk({26'h0, en}, 32'h0);
      rdchk(BCS_OFS_CMD_STS, 32'h0010_0000);
      $display("test mid-run reset done");
      close_out();
   end

   initial begin
      #100000;
      fails++;
      close_out();
   end
endmodule

// >>> src/bcs_regs.sv
// Command and primary status registers of the bridge, with their gating
`timescale 1ns/1ps
// Behaviour
// R1 - Command bit 0 clear: ignore primary I/O requests; RW, resets zero.
// R2 - Command bit 1 clear: ignore primary memory reads; RW, resets zero.
// R3 - Command bit 2 clear: no primary mastering, no secondary request acceptance.
// R4 - Command bit 3 reads zero; special cycles never targeted.
// R5 - Command bit 4 reads zero; bridge never originates write-and-invalidate itself.
// R6 - Command bits 5, 7, 9 read zero and ignore writes.
// R7 - Command bit 6 lets parity and poison events set status bit 24.
// R8 - Error messages go to root complex only in forward mode with bit 8.
// R9 - Command bit 10 set blocks the legacy interrupt; resets zero.
// R10 - Status bit 20 reads one: capability list present at 34h.
// R11 - Status bit 23 is read-only zero.
// R12 - Status bits 26:25 read zero.
// R13 - Bit 24 sets on poisoned completion or poisoned write with parity enable.
// R14 - Bit 27 sets when a primary request completes with completer abort.
// R15 - Bit 28 sets on received completer-abort completion.
// R16 - Bit 29 sets on received unsupported-request completion.
// R17 - Bit 30 sets when a fatal or non-fatal error message is sent.
// R18 - Bit 31 sets on detected poison or a poisoned completion received, regardless of parity enable.
// R19 - Status flags clear on write one, keep on write zero, reset zero.
// R20 - Writes to read-only and reserved command bits are ignored; they read zero.
module bcs_regs
   import bcs_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // Configuration access port
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [BCS_ADDR_W-1:0] CFG_ADDR,
   input wire logic [3:0] CFG_BE,
   input wire logic [31:0] CFG_WDATA,
   output logic [31:0] CFG_RDATA,
   output logic CFG_RD_VALID,
   // Command enables towards the bridge core
   output logic IO_SPACE_EN,
   output logic MEM_SPACE_EN,
   output logic BUS_MASTER_EN,
   output logic PARITY_RESP_EN,
   output logic SERR_EN,
   output logic INT_DISABLE,
   // Request gating
   input wire logic PRI_IO_REQ,
   output logic PRI_IO_ACCEPT,
   input wire logic PRI_MEM_RD_REQ,
   output logic PRI_MEM_RD_ACCEPT,
   input wire logic SEC_FWD_REQ,
   output logic SEC_FWD_ACCEPT,
   // Error message and interrupt gating
   input wire logic FWD_MODE,
   input wire logic ERR_MSG_REQ,
   output logic ERR_MSG_SEND,
   input wire logic INTA_REQ,
   output logic INTA_ASSERT,
   // Primary side error events, one-cycle pulses
   input wire logic EV_POISON_CPL_RX,
   input wire logic EV_POISON_WR_TX,
   input wire logic EV_POISON_DET,
   input wire logic EV_CA_SENT,
   input wire logic EV_CA_RX,
   input wire logic EV_UR_RX
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [BCS_CMD_W-1:0] cmd_q;
   logic [BCS_CMD_W-1:0] cmd_d;
   logic [BCS_NUM_FLAGS-1:0] flag_q;
   logic [BCS_NUM_FLAGS-1:0] flag_d;
   logic [BCS_NUM_FLAGS-1:0] flag_set;
   logic [BCS_NUM_FLAGS-1:0] flag_clr;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic rvalid_q;
   logic rvalid_d;
   logic hit;
   logic wr_hit;
   logic [31:0] word;
   logic err_send;

   assign hit = (CFG_ADDR == BCS_OFS_CMD_STS);
   assign wr_hit = CFG_WR && hit;

   // ---------------------------------------------------------------
   // Command register
   // ---------------------------------------------------------------
   // Only the six implemented bits take a write; the rest stay zero.
   always_comb begin
      cmd_d = cmd_q;
      if (wr_hit && CFG_BE[0]) begin
         cmd_d[7:0] = CFG_WDATA[7:0] & BCS_CMD_WR_MASK[7:0]; // R4 R5 R6 R20
      end
      if (wr_hit && CFG_BE[1]) begin
         cmd_d[15:8] = CFG_WDATA[15:8] & BCS_CMD_WR_MASK[15:8]; // R6 R20
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cmd_q <= BCS_CMD_RST; // R1 R2 R9
      end else begin
         cmd_q <= cmd_d;
      end
   end

   assign IO_SPACE_EN = cmd_q[BCS_CMD_IO];
   assign MEM_SPACE_EN = cmd_q[BCS_CMD_MEM];
   assign BUS_MASTER_EN = cmd_q[BCS_CMD_BME];
   assign PARITY_RESP_EN = cmd_q[BCS_CMD_PER];
   assign SERR_EN = cmd_q[BCS_CMD_SERR];
   assign INT_DISABLE = cmd_q[BCS_CMD_INTD];

   // ---------------------------------------------------------------
   // Gating of the core's requests
   // ---------------------------------------------------------------
   // Combinational so a request is refused in the same cycle it is made.
   assign PRI_IO_ACCEPT = PRI_IO_REQ && cmd_q[BCS_CMD_IO]; // R1
   assign PRI_MEM_RD_ACCEPT = PRI_MEM_RD_REQ && cmd_q[BCS_CMD_MEM]; // R2
   assign SEC_FWD_ACCEPT = SEC_FWD_REQ && cmd_q[BCS_CMD_BME]; // R3
   assign err_send = ERR_MSG_REQ && FWD_MODE && cmd_q[BCS_CMD_SERR]; // R8
   assign ERR_MSG_SEND = err_send;
   assign INTA_ASSERT = INTA_REQ && !cmd_q[BCS_CMD_INTD]; // R9

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   always_comb begin
      flag_set = '0;
      flag_set[BCS_F_MDPE] = cmd_q[BCS_CMD_PER] && (EV_POISON_CPL_RX || EV_POISON_WR_TX); // R7 R13
      flag_set[BCS_F_STA] = EV_CA_SENT; // R14
      flag_set[BCS_F_RTA] = EV_CA_RX; // R15
      flag_set[BCS_F_RMA] = EV_UR_RX; // R16
      flag_set[BCS_F_SSE] = err_send; // R17
      flag_set[BCS_F_DPE] = EV_POISON_DET || EV_POISON_CPL_RX; // R18
   end

   // A hardware event in the cycle of a clearing write wins over the clear.
   genvar gi;
   generate
      for (gi = 0; gi < BCS_NUM_FLAGS; gi++) begin : g_flag
         assign flag_clr[gi] = wr_hit && CFG_BE[BCS_FLAG_LANE]
                               && CFG_WDATA[BCS_FLAG_BIT[gi]]; // R19
         assign flag_d[gi] = flag_set[gi] || (flag_q[gi] && !flag_clr[gi]); // R19
      end
   endgenerate

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         flag_q <= BCS_FLAG_RST; // R19
      end else begin
         flag_q <= flag_d;
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   // Read data is registered; other offsets of config space read zero here.
   always_comb begin
      word = BCS_RD_ZERO;
      word[BCS_CMD_W-1:0] = cmd_q;
      word[BCS_STS_CAP] = BCS_STS_CAP_VAL; // R10
      word[BCS_STS_66M] = BCS_STS_66M_VAL;
      word[BCS_STS_FBB] = BCS_STS_FBB_VAL; // R11
      word[BCS_STS_DEVSEL_HI:BCS_STS_DEVSEL_LO] = BCS_STS_DEVSEL_VAL; // R12
      for (int i = 0; i < BCS_NUM_FLAGS; i++) begin
         word[BCS_FLAG_BIT[i]] = flag_q[i];
      end
      rvalid_d = CFG_RD;
      rdata_d = rdata_q;
      if (CFG_RD) begin
         rdata_d = hit ? word : BCS_RD_ZERO;
      end
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdata_q <= BCS_RD_ZERO;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign CFG_RDATA = rdata_q;
   assign CFG_RD_VALID = rvalid_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_rd_word;
      CFG_RD && hit;
   endsequence

   sequence s_clr_dpe;
      wr_hit && CFG_BE[BCS_FLAG_LANE] && CFG_WDATA[BCS_FLAG_BIT[BCS_F_DPE]];
   endsequence

   property p_io_gate;
      @(posedge REF_CLK) disable iff (SYS_RST)
      PRI_IO_REQ && !IO_SPACE_EN |-> !PRI_IO_ACCEPT;
   endproperty
   a_io_gate: assert property (p_io_gate) else $error("I/O accepted while disabled"); // R1

   property p_mem_gate;
      @(posedge REF_CLK) disable iff (SYS_RST)
      PRI_MEM_RD_REQ |-> (PRI_MEM_RD_ACCEPT == MEM_SPACE_EN);
   endproperty
   a_mem_gate: assert property (p_mem_gate) else $error("Memory read gating wrong"); // R2

   property p_bme_gate;
      @(posedge REF_CLK) disable iff (SYS_RST)
      SEC_FWD_ACCEPT |-> BUS_MASTER_EN && SEC_FWD_REQ;
   endproperty
   a_bme_gate: assert property (p_bme_gate) else $error("Forward accepted without mastering"); // R3

   property p_cmd_ro;
      @(posedge REF_CLK) disable iff (SYS_RST)
      wr_hit && CFG_BE[0] && CFG_BE[1] |=> (cmd_q & ~BCS_CMD_WR_MASK) == '0
         && cmd_q == ($past(CFG_WDATA[15:0]) & BCS_CMD_WR_MASK);
   endproperty
   a_cmd_ro: assert property (p_cmd_ro) else $error("Command write not masked"); // R20

   property p_rd_fixed;
      @(posedge REF_CLK) disable iff (SYS_RST)
      s_rd_word |=> CFG_RD_VALID && CFG_RDATA[BCS_STS_CAP]
         && !CFG_RDATA[BCS_STS_FBB]
         && CFG_RDATA[BCS_STS_DEVSEL_HI:BCS_STS_DEVSEL_LO] == BCS_STS_DEVSEL_VAL
         && (CFG_RDATA[BCS_CMD_W-1:0] & ~BCS_CMD_WR_MASK) == '0;
   endproperty
   a_rd_fixed: assert property (p_rd_fixed) else $error("Fixed status bits wrong"); // R10

   property p_mdpe;
      @(posedge REF_CLK) disable iff (SYS_RST)
      PARITY_RESP_EN && EV_POISON_WR_TX |=> flag_q[BCS_F_MDPE] ##0 s_rd_word
         |=> CFG_RDATA[BCS_FLAG_BIT[BCS_F_MDPE]];
   endproperty
   a_mdpe: assert property (p_mdpe) else $error("Parity flag not set"); // R13

   property p_mdpe_off;
      @(posedge REF_CLK) disable iff (SYS_RST)
      !PARITY_RESP_EN && !flag_q[BCS_F_MDPE] |=> !flag_q[BCS_F_MDPE];
   endproperty
   a_mdpe_off: assert property (p_mdpe_off) else $error("Parity flag set while disabled"); // R7

   property p_set_wins;
      @(posedge REF_CLK) disable iff (SYS_RST)
      s_clr_dpe ##0 EV_POISON_DET |=> flag_q[BCS_F_DPE];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("Event lost to clear"); // R18

   property p_w1c;
      @(posedge REF_CLK) disable iff (SYS_RST)
      s_clr_dpe ##0 !EV_POISON_DET && !EV_POISON_CPL_RX |=> !flag_q[BCS_F_DPE];
   endproperty
   a_w1c: assert property (p_w1c) else $error("Flag not cleared by one"); // R19

   property p_w0_keep;
      @(posedge REF_CLK) disable iff (SYS_RST)
      flag_q[BCS_F_STA] && wr_hit && !CFG_WDATA[BCS_FLAG_BIT[BCS_F_STA]]
         |=> flag_q[BCS_F_STA];
   endproperty
   a_w0_keep: assert property (p_w0_keep) else $error("Flag lost on zero write"); // R19

   property p_err_msg;
      @(posedge REF_CLK) disable iff (SYS_RST)
      ERR_MSG_SEND |-> SERR_EN && FWD_MODE ##1 flag_q[BCS_F_SSE];
   endproperty
   a_err_msg: assert property (p_err_msg) else $error("Error message gating wrong"); // R8

   property p_abort_flags;
      @(posedge REF_CLK) disable iff (SYS_RST)
      EV_CA_SENT && EV_CA_RX && EV_UR_RX |=> flag_q[BCS_F_STA] && flag_q[BCS_F_RTA]
         && flag_q[BCS_F_RMA];
   endproperty
   a_abort_flags: assert property (p_abort_flags) else $error("Abort flag not set"); // R14

   property p_inta;
      @(posedge REF_CLK) disable iff (SYS_RST)
      INT_DISABLE |-> !INTA_ASSERT;
   endproperty
   a_inta: assert property (p_inta) else $error("Interrupt asserted while disabled"); // R9

   property p_inta_on;
      @(posedge REF_CLK) disable iff (SYS_RST)
      INTA_REQ && !INT_DISABLE |-> INTA_ASSERT;
   endproperty
   a_inta_on: assert property (p_inta_on) else $error("Interrupt held back while enabled"); // R9

   property p_io_on;
      @(posedge REF_CLK) disable iff (SYS_RST)
      PRI_IO_REQ && IO_SPACE_EN |-> PRI_IO_ACCEPT;
   endproperty
   a_io_on: assert property (p_io_on) else $error("I/O refused while enabled"); // R1

   property p_sta;
      @(posedge REF_CLK) disable iff (SYS_RST)
      EV_CA_SENT |=> flag_q[BCS_F_STA];
   endproperty
   a_sta: assert property (p_sta) else $error("Signalled abort flag not set"); // R14

   property p_rta;
      @(posedge REF_CLK) disable iff (SYS_RST)
      EV_CA_RX |=> flag_q[BCS_F_RTA];
   endproperty
   a_rta: assert property (p_rta) else $error("Received abort flag not set"); // R15

   property p_rma;
      @(posedge REF_CLK) disable iff (SYS_RST)
      EV_UR_RX |=> flag_q[BCS_F_RMA];
   endproperty
   a_rma: assert property (p_rma) else $error("Unsupported request flag not set"); // R16

   property p_dpe;
      @(posedge REF_CLK) disable iff (SYS_RST)
      EV_POISON_DET || EV_POISON_CPL_RX |=> flag_q[BCS_F_DPE];
   endproperty
   a_dpe: assert property (p_dpe) else $error("Detected poison flag not set"); // R18

   property p_mdpe_set;
      @(posedge REF_CLK) disable iff (SYS_RST)
      PARITY_RESP_EN && (EV_POISON_CPL_RX || EV_POISON_WR_TX) |=> flag_q[BCS_F_MDPE];
   endproperty
   a_mdpe_set: assert property (p_mdpe_set) else $error("Parity flag missed an event"); // R13

   property p_rd_cmd;
      @(posedge REF_CLK) disable iff (SYS_RST)
      s_rd_word |=> CFG_RDATA[BCS_CMD_W-1:0] == $past(cmd_q);
   endproperty
   a_rd_cmd: assert property (p_rd_cmd) else $error("Command read back wrong"); // R20

   property p_cmd_keep;
      @(posedge REF_CLK) disable iff (SYS_RST)
      !wr_hit |=> cmd_q == $past(cmd_q);
   endproperty
   a_cmd_keep: assert property (p_cmd_keep) else $error("Command changed without a write"); // R20

   property p_ro_cmd;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (cmd_q & ~BCS_CMD_WR_MASK) == '0;
   endproperty
   a_ro_cmd: assert property (p_ro_cmd) else $error("Read-only command bit set"); // R6

endmodule
